//--- src/skip_logic_params.svh
// Constants for the increment and bit-test skip logic
`ifndef SKIP_LOGIC_PARAMS_SVH
`define SKIP_LOGIC_PARAMS_SVH
`define DATA_W 8
`define ADDR_W 8
`define MEM_DEPTH 256
`define BITIDX_W 3
`define INC_ONE 8'h01
`define ZERO_BYTE 8'h00
`define ACC_RESET 8'h00
`define FLAGS_RESET 6'h00
`define SKIP_CYCLES 2
`define FLAG_TIMEOUT 5
`define FLAG_POWERDOWN 4
`define FLAG_OVERFLOW 3
`define FLAG_ZERO 2
`define FLAG_AUX_CARRY 1
`define FLAG_CARRY 0
`endif

//--- src/skip_logic_pkg.sv
// Types shared by the skip logic
package skip_logic_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_INC_MEM = 4'b0010,
        OP_INC_ACC = 4'b0100,
        OP_BIT_SET = 4'b1000
    } op_type;
    typedef struct packed {
        op_type op;
        logic [7:0] addr;
        logic [2:0] bit_idx;
    } instr_type;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b10
    } state_type;
endpackage

//--- src/data_mem.sv
// Small data memory with registered read data
`timescale 1ns/1ps
`include "skip_logic_params.svh"
module data_mem (
    input wire logic i_clk,
    input wire logic [`ADDR_W-1:0] i_raddr,
    output logic [`DATA_W-1:0] o_rdata,
    input wire logic i_we,
    input wire logic [`ADDR_W-1:0] i_waddr,
    input wire logic [`DATA_W-1:0] i_wdata
);
    logic [`DATA_W-1:0] mem_r [0:`MEM_DEPTH-1];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_r[i_raddr];
    end
endmodule

//--- src/increment_bit_test_skip_logic.sv
// Execution and skip control for increment-skip and bit-test-skip instructions
`timescale 1ns/1ps
`include "skip_logic_params.svh"
module increment_bit_test_skip_logic (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire skip_logic_pkg::instr_type i_instr,
    input wire logic [5:0] i_flags,
    input wire logic i_mem_we,
    input wire logic [`ADDR_W-1:0] i_mem_waddr,
    input wire logic [`DATA_W-1:0] i_mem_wdata,
    output logic o_ready,
    output logic o_done,
    output logic o_skip,
    output logic o_discard,
    output logic [`DATA_W-1:0] o_acc,
    output logic [5:0] o_flags,
    output logic [`DATA_W-1:0] o_mem_byte
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic is_op(input skip_logic_pkg::op_type a,
                                   input skip_logic_pkg::op_type b);
        is_op = (a == b);
    endfunction

    skip_logic_pkg::state_type state_r;
    skip_logic_pkg::state_type state_nxt;
    skip_logic_pkg::instr_type instr_r;
    logic fetch_r;
    logic [`DATA_W-1:0] rdata;
    skip_logic_pkg::instr_type instr_nxt;
    logic [`DATA_W-1:0] acc_nxt;
    logic [`DATA_W-1:0] mem_byte_nxt;

    // Memory read takes a cycle, so each op spends one fetch cycle before execute
    wire accept = i_valid && o_ready;
    wire exec = fetch_r;
    wire op_inc_mem = is_op(instr_r.op, skip_logic_pkg::OP_INC_MEM);
    wire op_inc_acc = is_op(instr_r.op, skip_logic_pkg::OP_INC_ACC);
    wire op_bit_set = is_op(instr_r.op, skip_logic_pkg::OP_BIT_SET);
    wire [`DATA_W-1:0] inc_val = rdata + `INC_ONE;
    wire inc_zero = (inc_val == `ZERO_BYTE);
    wire bit_val = rdata[instr_r.bit_idx];
    wire skip_now = exec && (((op_inc_mem || op_inc_acc) && inc_zero)
                             || (op_bit_set && bit_val));
    // Only the memory increment writes back; the other two leave memory alone
    wire wb_en = exec && op_inc_mem;
    wire mem_we = wb_en || (i_mem_we && !wb_en);
    wire [`ADDR_W-1:0] mem_waddr = wb_en ? instr_r.addr : i_mem_waddr;
    wire [`DATA_W-1:0] mem_wdata = wb_en ? inc_val : i_mem_wdata;
    wire [`ADDR_W-1:0] mem_raddr = accept ? i_instr.addr : instr_r.addr;

    // Hold-or-load selects keep every register clocked on every edge
    assign instr_nxt = accept ? i_instr : instr_r;
    assign acc_nxt = (exec && op_inc_acc) ? inc_val : o_acc;
    assign mem_byte_nxt = exec ? (wb_en ? inc_val : rdata) : o_mem_byte;

    data_mem u_mem (
        .i_clk(i_ref_clk),
        .i_raddr(mem_raddr),
        .o_rdata(rdata),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        case (state_r)
            skip_logic_pkg::ST_EXEC: state_nxt = skip_now ? skip_logic_pkg::ST_DUMMY
                                                          : skip_logic_pkg::ST_EXEC;
            skip_logic_pkg::ST_DUMMY: state_nxt = skip_logic_pkg::ST_EXEC;
            default: state_nxt = skip_logic_pkg::ST_EXEC;
        endcase
    end

    // Ready stays low through the dummy cycle so the discarded slot takes nothing
    wire ready_nxt = !accept && !skip_now && (state_nxt == skip_logic_pkg::ST_EXEC);

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= skip_logic_pkg::ST_EXEC;
            fetch_r <= 1'b0;
            instr_r <= '{op: skip_logic_pkg::OP_NONE, addr: 8'h00, bit_idx: 3'h0};
        end else begin
            state_r <= state_nxt;
            fetch_r <= accept;
            instr_r <= instr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ready <= 1'b0;
            o_done <= 1'b0;
            o_skip <= 1'b0;
            o_discard <= 1'b0;
            o_acc <= `ACC_RESET;
            o_flags <= `FLAGS_RESET;
            o_mem_byte <= `ZERO_BYTE;
        end else begin
            o_ready <= ready_nxt;
            o_done <= exec;
            o_skip <= skip_now;
            o_discard <= skip_now;
            o_flags <= i_flags;
            o_acc <= acc_nxt;
            o_mem_byte <= mem_byte_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence skip_seq;
        exec && skip_now ##1 state_r == skip_logic_pkg::ST_DUMMY;
    endsequence

    inc_mem_skip_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_inc_mem |=> o_mem_byte == $past(inc_val) && o_skip == $past(inc_zero))
        else $error("Memory increment result or skip wrong");
    dummy_cycle_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        skip_seq |-> o_discard ##1 state_r == skip_logic_pkg::ST_EXEC && !o_discard)
        else $error("Skip did not insert exactly one dummy cycle");
    no_skip_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && !skip_now |=> !o_discard && state_r == skip_logic_pkg::ST_EXEC)
        else $error("Unskipped op took extra cycle");
    acc_load_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_inc_acc |=> o_acc == $past(rdata) + 8'h01)
        else $error("Accumulator not loaded with byte plus one");
    acc_skip_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_inc_acc |=> o_skip == (o_acc == 8'h00))
        else $error("Accumulator increment skip wrong");
    bit_skip_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_bit_set |-> !wb_en ##1 o_skip == $past(bit_val))
        else $error("Bit test skip wrong or memory written");
    flags_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec |=> o_flags == $past(i_flags))
        else $error("Status flags changed");
    acc_nowrite_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_inc_acc |-> !mem_we || !wb_en)
        else $error("Accumulator op wrote memory");

    // ------------------------------------------------------------
    // Checks on the sequencing
    // ------------------------------------------------------------
    // A skip costs exactly one bubble: ready low with the skip, back high after it
    sequence skip_gap_seq;
        !o_ready && o_skip ##1 o_ready && !o_skip;
    endsequence

    sequence wrap_seq;
        exec && (op_inc_mem || op_inc_acc) && inc_zero;
    endsequence

    ready_drop_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        accept |=> !o_ready && exec)
        else $error("Ready stayed high after an accept");
    noskip_ready_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && !skip_now |=> o_ready && o_done)
        else $error("Unskipped op did not finish in one cycle");
    skip_gap_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && skip_now |=> skip_gap_seq)
        else $error("Skip did not cost exactly one extra cycle");
    discard_pair_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_discard == o_skip)
        else $error("Discard and skip disagree");
    done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_done |=> !o_done)
        else $error("Done lasted more than one cycle");
    skip_after_exec_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_skip |-> $past(exec))
        else $error("Skip reported without an execute cycle");
    dummy_no_accept_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        state_r == skip_logic_pkg::ST_DUMMY |-> !o_ready)
        else $error("Ready high during the dummy cycle");
    ready_idle_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_ready |-> !exec && state_r == skip_logic_pkg::ST_EXEC)
        else $error("Ready high while busy");

    // ------------------------------------------------------------
    // Checks on the data path
    // ------------------------------------------------------------
    wrap_skip_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        wrap_seq |=> o_skip && o_discard)
        else $error("Wrap to zero did not skip");
    mem_writeback_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && op_inc_mem |-> mem_we && mem_waddr == instr_r.addr
                               && mem_wdata == rdata + 8'h01)
        else $error("Memory increment not written back");
    acc_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        !(exec && op_inc_acc) |=> $stable(o_acc))
        else $error("Accumulator changed by another op");
    mem_byte_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        exec && !op_inc_mem |=> o_mem_byte == $past(rdata))
        else $error("Byte changed by a non-writing op");
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the increment and bit-test skip logic
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // Signals and table of cases
    // ------------------------------------------------------------
    typedef struct packed {
        skip_logic_pkg::op_type op;
        logic [7:0] addr;
        logic [2:0] bidx;
        logic [7:0] mem;
        logic [5:0] fl;
        logic sk_e;
        logic [7:0] res_e;
    } row_type;
    localparam skip_logic_pkg::op_type k_mem = skip_logic_pkg::OP_INC_MEM;
    localparam skip_logic_pkg::op_type k_acc = skip_logic_pkg::OP_INC_ACC;
    localparam skip_logic_pkg::op_type k_bit = skip_logic_pkg::OP_BIT_SET;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_valid = 1'b0;
    skip_logic_pkg::instr_type i_instr = '{skip_logic_pkg::OP_NONE, 8'h00, 3'h0};
    logic [5:0] i_flags = 6'h00;
    logic i_mem_we = 1'b0;
    logic [7:0] i_mem_waddr = 8'h00;
    logic [7:0] i_mem_wdata = 8'h00;
    logic o_ready, o_done, o_skip, o_discard;
    logic [7:0] o_acc, o_mem_byte;
    logic [5:0] o_flags;
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] acc_e, mem_a;
    row_type rows [8];
    increment_bit_test_skip_logic DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_valid(i_valid), .i_instr(i_instr), .i_flags(i_flags), .i_mem_we(i_mem_we),
        .i_mem_waddr(i_mem_waddr), .i_mem_wdata(i_mem_wdata), .o_ready(o_ready),
        .o_done(o_done), .o_skip(o_skip), .o_discard(o_discard), .o_acc(o_acc),
        .o_flags(o_flags), .o_mem_byte(o_mem_byte));
    always #10 i_ref_clk = ~i_ref_clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic preload(input logic [7:0] a, input logic [7:0] d);
        i_mem_we = 1'b1;
        i_mem_waddr = a;
        i_mem_wdata = d;
        @(posedge i_ref_clk);
        #1 i_mem_we = 1'b0;
    endtask
    // Ready is sampled a cycle after completion too: a skip must cost one extra cycle
    task automatic run(input skip_logic_pkg::op_type op, input logic [7:0] a,
                       input logic [2:0] b, input logic s);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 20) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        check("ready_wait", 8'(o_ready), 8'h01);
        i_valid = 1'b1;
        i_instr = '{op, a, b};
        @(posedge i_ref_clk);
        #1 i_valid = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 20) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        check("done", 8'(o_done), 8'h01);
        check("latency", 8'(n), 8'h01);
        check("skip", 8'(o_skip), 8'(s));
        check("discard", 8'(o_discard), 8'(s));
        check("ready", 8'(o_ready), 8'(!s));
        check("flags", 8'(o_flags), 8'(i_flags));
        @(posedge i_ref_clk);
        #1 check("ready_next", 8'(o_ready), 8'h01);
        check("done_pulse", 8'(o_done), 8'h00);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        // Columns: op, address, bit index, byte, flags, skip expected, result byte
        rows[0] = '{k_acc, 8'h10, 3'h0, 8'h7f, 6'h3f, 1'b0, 8'h80};
        rows[1] = '{k_acc, 8'h11, 3'h0, 8'hff, 6'h00, 1'b1, 8'h00};
        rows[2] = '{k_mem, 8'h12, 3'h0, 8'hff, 6'h2a, 1'b1, 8'h00};
        rows[3] = '{k_mem, 8'h13, 3'h0, 8'hfe, 6'h15, 1'b0, 8'hff};
        rows[4] = '{k_bit, 8'h14, 3'h7, 8'h80, 6'h01, 1'b1, 8'h80};
        rows[5] = '{k_bit, 8'h15, 3'h6, 8'hbf, 6'h20, 1'b0, 8'hbf};
        rows[6] = '{k_bit, 8'h16, 3'h0, 8'h01, 6'h3e, 1'b1, 8'h01};
        rows[7] = '{k_bit, 8'h17, 3'h3, 8'hf7, 6'h0c, 1'b0, 8'hf7};
        acc_e = 8'h00;
        repeat (4) @(posedge i_ref_clk);
        #1 check("acc_rst", o_acc, 8'h00);
        check("skip_rst", 8'(o_skip), 8'h00);
        check("ready_rst", 8'(o_ready), 8'h00);
        i_resetn = 1'b1;
        foreach (rows[i]) begin
            i_flags = rows[i].fl;
            preload(rows[i].addr, rows[i].mem);
            if (rows[i].op == k_acc) acc_e = rows[i].res_e;
            run(rows[i].op, rows[i].addr, rows[i].bidx, rows[i].sk_e);
            check("acc", o_acc, acc_e);
            mem_a = (rows[i].op == k_acc) ? rows[i].mem : rows[i].res_e;
            // Read the byte back through the accumulator path to see what memory holds
            acc_e = mem_a + 8'h01;
            run(k_acc, rows[i].addr, 3'h0, acc_e == 8'h00);
            check("mem_after", o_mem_byte, mem_a);
            check("acc_after", o_acc, acc_e);
        end
        // Second reset in mid-run, then a bit test on a fresh byte
        i_resetn = 1'b0;
        @(posedge i_ref_clk);
        #1 check("acc_rst2", o_acc, 8'h00);
        check("ready_rst2", 8'(o_ready), 8'h00);
        check("flags_rst2", 8'(o_flags), 8'h00);
        i_resetn = 1'b1;
        preload(8'h20, 8'h04);
        run(k_bit, 8'h20, 3'h2, 1'b1);
        report_and_stop();
    end
    initial begin
        #100000 miscompares++;
        report_and_stop();
    end
endmodule
